// ---- include/mse_regs.svh ----
// Constants for the monitor security entry block.
`ifndef MSE_REGS_SVH
`define MSE_REGS_SVH
`define MSE_KEY_BYTES      4'h8
`define MSE_DATA_BITS      4'h8
`define MSE_FILLER         8'hAD
`define MSE_POR_BIT        7
`define MSE_BAUD_DIV       16'h0010
`define MSE_BREAK_BITS     4'hC
`define MSE_CMD_READ       8'h4A
`define MSE_CMD_VERSION    8'h16
`define MSE_VERSION        8'h01
`define MSE_RSR_POR        8'h80
`define MSE_RSR_PIN        8'h40
`define MSE_FIFO_DEPTH     16
`endif

// ---- include/mse_pkg.sv ----
// Types shared by the monitor security entry block.
package mse_pkg;
  typedef enum logic [2:0]
  {
    MSE_TX_IDLE  = 3'b000,
    MSE_TX_START = 3'b001,
    MSE_TX_DATA  = 3'b010,
    MSE_TX_STOP  = 3'b011,
    MSE_TX_BRK   = 3'b100
  } mse_tx_state_t;
  typedef enum logic [2:0]
  {
    MSE_MON_KEY  = 3'b000,
    MSE_MON_CMD  = 3'b001,
    MSE_MON_AHI  = 3'b010,
    MSE_MON_ALO  = 3'b011,
    MSE_MON_DONE = 3'b100
  } mse_mon_state_t;
endpackage

// ---- include/mse_fifo_if.sv ----
// Handshake bundle between the monitor core and its transmit FIFO.
`timescale 1ns/1ps
`default_nettype none
interface mse_fifo_if #(parameter int WIDTH = 9);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport producer (output in_valid, in_data, input in_ready,
                    input out_valid, out_data, output out_ready);
  modport fifo (input in_valid, in_data, output in_ready,
                output out_valid, out_data, input out_ready);
endinterface
`default_nettype wire

// ---- design/mse_fifo.sv ----
// Synchronous FIFO holding bytes queued for transmission.
`timescale 1ns/1ps
`default_nettype none
module mse_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic clock,  // System clock.
  input  wire logic rst_n,  // Synchronous reset, active low.
  mse_fifo_if.fifo  port    // Both handshake sides.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  wire              do_wr = port.in_valid && port.in_ready;
  wire              do_rd = port.out_valid && port.out_ready;
  assign port.in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign port.out_valid = (count_ff != '0);
  assign port.out_data  = mem[rd_ptr_ff];
  assign nxt_count = count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  always_ff @(posedge clock)
  begin
    if (do_wr)
      mem[wr_ptr_ff] <= port.in_data;
  end
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + AW'(do_wr);
      rd_ptr_ff <= rd_ptr_ff + AW'(do_rd);
      count_ff  <= nxt_count;
    end
  end
endmodule
`default_nettype wire

// ---- design/mse_monitor.sv ----
// Resident monitor: security entry, echo, break and guarded memory reads.
// What this block does
// - In monitor mode every received byte is echoed back unprompted.
// - After eight security bytes a break is sent, pass or fail.
// - Reset cause register reports last reset, top bit set for power-on.
// - Invalid addresses, and protected ones while secured, read back the filler byte.
// - Failed security still serves commands but hides program memory.
`timescale 1ns/1ps
`default_nettype none
`include "mse_regs.svh"
module mse_monitor #(
  parameter logic [15:0] BAUD_DIV  = `MSE_BAUD_DIV,
  parameter int          FIFO_DEPTH = `MSE_FIFO_DEPTH
) (
  input  wire logic        clock,         // System clock, 200 MHz.
  input  wire logic        rst_n,         // Synchronous reset, active low.
  input  wire logic        por_cause,     // Last reset was power-on.
  input  wire logic [63:0] security_key,  // Stored eight-byte key, byte 0 low.
  input  wire logic        serial_rx,     // Serial line from the host.
  output logic             serial_tx,     // Serial line to the host.
  output logic [15:0]      mem_addr,      // Memory read address.
  input  wire logic [7:0]  mem_rdata,     // Memory read data, same cycle.
  input  wire logic        mem_valid,     // Address is populated.
  input  wire logic        mem_protected, // Address holds program memory.
  output logic             secured,       // Security comparison failed.
  output logic             entered,       // Eight key bytes taken, break queued.
  output logic [7:0]       reset_cause_register // Last reset cause.
);
  logic       rx_s1_ff, rx_s2_ff;
  logic [15:0] rx_cnt_ff;
  logic [3:0]  rx_bit_ff;
  logic [7:0]  rx_sh_ff;
  logic        rx_busy_ff;
  logic        rx_done_ff;
  logic [7:0]  rx_byte_ff;
  mse_pkg::mse_tx_state_t  tx_st_ff;
  mse_pkg::mse_mon_state_t mon_st_ff;
  logic [15:0] tx_cnt_ff;
  logic [3:0]  tx_bit_ff;
  logic [7:0]  tx_sh_ff;
  logic        tx_ff;
  logic [3:0]  key_idx_ff;
  logic        match_ff;
  logic        cmd_ver_ff;
  logic [7:0]  ahi_ff;
  logic [15:0] addr_ff;
  logic        rsr_taken_ff;
  mse_fifo_if #(.WIDTH(9)) q ();
  mse_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) mse_fifo_inst (.clock(clock), .rst_n(rst_n), .port(q));
  // Receiver samples the mid-point of each bit.
  wire rx_tick  = (rx_cnt_ff == 16'h0000);
  wire rx_start = !rx_busy_ff && !rx_s2_ff;
  always_ff @(posedge clock)
  begin
    rx_s1_ff <= serial_rx;
    rx_s2_ff <= rx_s1_ff;
    if (!rst_n)
    begin
      rx_busy_ff <= 1'b0;
      rx_cnt_ff  <= 16'h0000;
      rx_bit_ff  <= 4'h0;
      rx_sh_ff   <= 8'h00;
      rx_done_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end
    else
    begin
      rx_done_ff <= 1'b0;
      if (rx_start)
      begin
        rx_busy_ff <= 1'b1;
        rx_cnt_ff  <= BAUD_DIV + (BAUD_DIV >> 1);
        rx_bit_ff  <= 4'h0;
      end
      else if (rx_busy_ff && rx_tick)
      begin
        rx_cnt_ff <= BAUD_DIV - 16'h0001;
        if (rx_bit_ff == `MSE_DATA_BITS)
        begin
          rx_busy_ff <= 1'b0;
          rx_done_ff <= rx_s2_ff;
          rx_byte_ff <= rx_sh_ff;
        end
        else
        begin
          rx_sh_ff  <= {rx_s2_ff, rx_sh_ff[7:1]};
          rx_bit_ff <= rx_bit_ff + 4'h1;
        end
      end
      else if (rx_busy_ff)
        rx_cnt_ff <= rx_cnt_ff - 16'h0001;
    end
  end
  // Queue entries: bit 8 marks a break rather than a data byte.
  wire        is_key   = (mon_st_ff == mse_pkg::MSE_MON_KEY);
  wire        key_hit  = (rx_byte_ff == security_key[key_idx_ff[2:0]*8 +: 8]);
  wire        last_key = is_key && (key_idx_ff == `MSE_KEY_BYTES - 4'h1);
  wire        rd_allow = mem_valid && !(mem_protected && secured);
  wire [7:0]  rd_byte  = cmd_ver_ff ? `MSE_VERSION :
                         rd_allow ? mem_rdata : `MSE_FILLER;
  wire        ans_rd   = (mon_st_ff == mse_pkg::MSE_MON_ALO) && rx_done_ff;
  wire        push_brk = rx_done_ff && last_key;
  assign mem_addr = {ahi_ff, rx_byte_ff};
  // The echo has priority on the FIFO input; the holding slot drains in the next free cycle.
  assign q.in_valid = rx_done_ff || hold_v_ff;
  assign q.in_data  = rx_done_ff ? {1'b0, rx_byte_ff} : hold_ff;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      mon_st_ff    <= mse_pkg::MSE_MON_KEY;
      key_idx_ff   <= 4'h0;
      match_ff     <= 1'b1;
      cmd_ver_ff   <= 1'b0;
      ahi_ff       <= 8'h00;
      addr_ff      <= 16'h0000;
      rsr_taken_ff <= 1'b0;
      reset_cause_register <= 8'h00;
    end
    else
    begin
      if (!rsr_taken_ff)
      begin
        rsr_taken_ff <= 1'b1;
        reset_cause_register <= por_cause ? `MSE_RSR_POR : `MSE_RSR_PIN;
      end
      if (rx_done_ff)
      begin
        case (mon_st_ff)
          mse_pkg::MSE_MON_KEY:
          begin
            match_ff   <= match_ff && key_hit;
            key_idx_ff <= key_idx_ff + 4'h1;
            if (last_key)
              mon_st_ff <= mse_pkg::MSE_MON_CMD;
          end
          mse_pkg::MSE_MON_CMD:
          begin
            if (rx_byte_ff == `MSE_CMD_READ)
              mon_st_ff <= mse_pkg::MSE_MON_AHI;
            cmd_ver_ff <= 1'b0;
            if (rx_byte_ff == `MSE_CMD_VERSION)
            begin
              cmd_ver_ff <= 1'b1;
              mon_st_ff  <= mse_pkg::MSE_MON_DONE;
            end
          end
          mse_pkg::MSE_MON_AHI:
          begin
            ahi_ff    <= rx_byte_ff;
            mon_st_ff <= mse_pkg::MSE_MON_ALO;
          end
          mse_pkg::MSE_MON_ALO:
          begin
            addr_ff   <= mem_addr;
            mon_st_ff <= mse_pkg::MSE_MON_CMD;
          end
          default:
            mon_st_ff <= mse_pkg::MSE_MON_CMD;
        endcase
      end
      else if (mon_st_ff == mse_pkg::MSE_MON_DONE)
        mon_st_ff <= mse_pkg::MSE_MON_CMD;
    end
  end
  // Secondary words (break, read or version answer) wait in a one-entry slot and join the FIFO behind
  // the echo, so the host always hears the echo first.
  logic [8:0] hold_ff;
  logic       hold_v_ff;
  wire        ver_ans = (mon_st_ff == mse_pkg::MSE_MON_DONE);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      hold_v_ff <= 1'b0;
      hold_ff   <= 9'h000;
    end
    else if (push_brk)
    begin
      hold_v_ff <= 1'b1;
      hold_ff   <= 9'h100;
    end
    else if (ans_rd || ver_ans)
    begin
      hold_v_ff <= 1'b1;
      hold_ff   <= {1'b0, rd_byte};
    end
    else if (hold_v_ff && !rx_done_ff && q.in_ready)
      hold_v_ff <= 1'b0;
  end
  wire [8:0] tx_word = q.out_data;
  wire       tx_have = q.out_valid;
  assign secured   = rsr_taken_ff && (mon_st_ff != mse_pkg::MSE_MON_KEY) && !match_ff;
  assign entered   = (mon_st_ff != mse_pkg::MSE_MON_KEY);
  // Transmitter; data shifts LSB-first and a break holds the line low, both on the same bit clock.
  wire tx_tick = (tx_cnt_ff == 16'h0000);
  assign q.out_ready = (tx_st_ff == mse_pkg::MSE_TX_IDLE);
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      tx_st_ff  <= mse_pkg::MSE_TX_IDLE;
      tx_cnt_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_sh_ff  <= 8'h00;
      tx_ff     <= 1'b1;
    end
    else
    begin
      tx_cnt_ff <= tx_tick ? BAUD_DIV - 16'h0001 : tx_cnt_ff - 16'h0001;
      case (tx_st_ff)
        mse_pkg::MSE_TX_IDLE:
        begin
          tx_ff <= 1'b1;
          if (tx_have)
          begin
            tx_sh_ff  <= tx_word[7:0];
            tx_bit_ff <= 4'h0;
            tx_cnt_ff <= BAUD_DIV - 16'h0001;
            tx_ff     <= 1'b0;
            tx_st_ff  <= tx_word[8] ? mse_pkg::MSE_TX_BRK : mse_pkg::MSE_TX_DATA;
          end
        end
        mse_pkg::MSE_TX_DATA:
          if (tx_tick)
          begin
            tx_ff     <= tx_sh_ff[0];
            tx_sh_ff  <= {1'b1, tx_sh_ff[7:1]};
            tx_bit_ff <= tx_bit_ff + 4'h1;
            if (tx_bit_ff == `MSE_DATA_BITS)
            begin
              tx_ff    <= 1'b1;
              tx_st_ff <= mse_pkg::MSE_TX_STOP;
            end
          end
        mse_pkg::MSE_TX_STOP:
          if (tx_tick)
            tx_st_ff <= mse_pkg::MSE_TX_IDLE;
        mse_pkg::MSE_TX_BRK:
          if (tx_tick)
          begin
            tx_ff     <= 1'b0;
            tx_bit_ff <= tx_bit_ff + 4'h1;
            if (tx_bit_ff == `MSE_BREAK_BITS)
            begin
              tx_ff    <= 1'b1;
              tx_st_ff <= mse_pkg::MSE_TX_STOP;
            end
          end
        default:
          tx_st_ff <= mse_pkg::MSE_TX_IDLE;
      endcase
    end
  end
  assign serial_tx = tx_ff;
endmodule
`default_nettype wire

// ---- verif/mse_host.sv ----
// Host model: serial sender and receiver with break detection.
`timescale 1ns/1ps
`default_nettype none
module mse_host #(
  parameter int BAUD_DIV = 4
) (
  input  wire logic clock,    // System clock.
  input  wire logic line_in,  // Device transmit line.
  output logic      line_out  // Host transmit line, idle high.
);
  logic [8:0] rx_q[$];
  logic [8:0] sh;
  // The board loopback returns every host character as well, so the host hears both lines.
  wire        rx_line = line_in & line_out;
  initial line_out = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
      repeat (BAUD_DIV) @(posedge clock) line_out <= frame[i];
  endtask
  // Bit 8 of a queued entry marks a break.
  always
  begin
    @(negedge rx_line);
    repeat (BAUD_DIV / 2) @(posedge clock);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BAUD_DIV) @(posedge clock);
      sh[i] = rx_line;
    end
    if (sh == 9'h000)
    begin
      rx_q.push_back(9'h100);
      for (int k = 0; k < 2000 && !rx_line; k++)
        @(posedge clock);
    end
    else
      rx_q.push_back({1'b0, sh[7:0]});
  end
endmodule
`default_nettype wire

// ---- verif/mse_monitor_chk.sv ----
// Port checker for the monitor security entry block.
`timescale 1ns/1ps
`default_nettype none
module mse_monitor_chk #(
  parameter logic [15:0] BAUD_DIV = 16'h0010
) (
  input wire logic       clock,               // System clock.
  input wire logic       rst_n,               // Reset, active low.
  input wire logic       por_cause,           // Power-on cause.
  input wire logic       serial_rx,           // Host line.
  input wire logic       serial_tx,           // Device line.
  input wire logic       secured,             // Secured flag.
  input wire logic       entered,             // Entry flag.
  input wire logic [7:0] reset_cause_register // Reset cause.
);
  logic [15:0] low_ff;
  logic [15:0] idle_ff;
  logic [15:0] nxt_low;
  logic [15:0] nxt_idle;
  assign nxt_low  = serial_tx ? 16'h0000 : low_ff + {15'h0000, low_ff != 16'hFFFF};
  assign nxt_idle = !serial_tx ? 16'h0000 : idle_ff + {15'h0000, idle_ff != 16'hFFFF};
  always_ff @(posedge clock)
  begin
    low_ff  <= rst_n ? nxt_low : 16'h0000;
    idle_ff <= rst_n ? nxt_idle : 16'h0000;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_echo;
    $fell(serial_rx) && idle_ff > 12 * BAUD_DIV |-> ##[1:200] $fell(serial_tx);
  endproperty
  a_echo: assert property (p_echo) else $error("no echo");
  property p_break;
    $rose(entered) |-> ##[1:1000] (low_ff > 10 * BAUD_DIV);
  endproperty
  a_break: assert property (p_break) else $error("no break");
  property p_entered_hold;
    $past(entered) |-> entered;
  endproperty
  a_entered_hold: assert property (p_entered_hold) else $error("entry lost");
  property p_cause;
    $rose(entered) |-> reset_cause_register == (por_cause ? 8'h80 : 8'h40);
  endproperty
  a_cause: assert property (p_cause) else $error("bad reset cause");
  property p_sec_rise;
    $rose(secured) |-> entered;
  endproperty
  a_sec_rise: assert property (p_sec_rise) else $error("early secure");
  property p_sec_hold;
    entered && $past(entered) |-> $stable(secured);
  endproperty
  a_sec_hold: assert property (p_sec_hold) else $error("secure changed");
  c_entry: cover property ($rose(entered));
  c_secured: cover property ($rose(secured));
  c_tx: cover property ($fell(serial_tx));
endmodule
bind mse_monitor mse_monitor_chk #(.BAUD_DIV(BAUD_DIV)) mse_monitor_chk_inst (
  .clock(clock), .rst_n(rst_n), .por_cause(por_cause), .serial_rx(serial_rx),
  .serial_tx(serial_tx), .secured(secured), .entered(entered),
  .reset_cause_register(reset_cause_register));
`default_nettype wire

// ---- verif/tb_top.sv ----
// Testbench for the monitor security entry block.
`timescale 1ns/1ps
`default_nettype none
`include "mse_regs.svh"
module tb_top;
  logic        clock;
  logic        rst_n;
  logic        por_cause;
  logic [63:0] key;
  logic        serial_rx;
  logic        serial_tx;
  logic [15:0] mem_addr;
  logic        secured;
  logic        entered;
  logic [7:0]  cause;
  int          bad_count;
  int          n_compared;
  int          seed;
  logic [6:0]  flags;
  logic        vec_filler;
  always #2.5 clock = ~clock;
  mse_monitor #(.BAUD_DIV(16'h0004), .FIFO_DEPTH(16)) mse_monitor_inst (
    .clock(clock), .rst_n(rst_n), .por_cause(por_cause), .security_key(key),
    .serial_rx(serial_rx), .serial_tx(serial_tx), .mem_addr(mem_addr),
    .mem_rdata(mem_addr[7:0] ^ mem_addr[15:8]), .mem_valid(mem_addr >= 16'h8000),
    .mem_protected(mem_addr >= 16'hC000), .secured(secured), .entered(entered),
    .reset_cause_register(cause));
  mse_host #(.BAUD_DIV(4)) mse_host_inst (.clock(clock), .line_in(serial_tx),
    .line_out(serial_rx));
  function automatic logic [7:0] mem_exp(input logic [15:0] a, input logic sec);
    return (a < 16'h8000 || (sec && a >= 16'hC000)) ? `MSE_FILLER : a[7:0] ^ a[15:8];
  endfunction
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic get_rx(output logic [8:0] v);
    for (int i = 0; i < 4000 && mse_host_inst.rx_q.size() == 0; i++)
      @(posedge clock);
    if (mse_host_inst.rx_q.size() == 0)
    begin
      bad_count++;
      $display("mismatch at %0t: no answer", $time);
      summarize;
    end
    else
      v = mse_host_inst.rx_q.pop_front();
  endtask
  task automatic send_echo(input logic [7:0] b);
    logic [8:0] v;
    logic       lb;
    repeat (64) @(posedge clock);
    mse_host_inst.send_byte(b);
    // First copy comes from the board loopback, second from the device monitor.
    get_rx(v);
    cmp(v, {1'b0, b});
    lb = (v === {1'b0, b});
    get_rx(v);
    cmp(v, {1'b0, b});
    flags[0] = flags[0] | lb;
    flags[1] = flags[1] | (v === {1'b0, b});
    flags[2] = flags[2] & lb & (v === {1'b0, b});
  endtask
  task automatic entry(input logic por, input logic [63:0] sent, input logic sec);
    logic [8:0] v;
    rst_n <= 1'b0;
    por_cause <= por;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    flags = 7'h04;
    for (int i = 0; i < 8; i++)
      send_echo(sent[8*i +: 8]);
    get_rx(v);
    cmp(v, 9'h100);
    flags[3] = (v === 9'h100);
    cmp({8'h00, entered}, 9'h001);
    cmp({8'h00, secured}, {8'h00, sec});
    cmp({1'b0, cause}, por ? 9'h080 : 9'h040);
    send_echo(`MSE_CMD_VERSION);
    get_rx(v);
    cmp(v, {1'b0, `MSE_VERSION});
    flags[4] = (v === {1'b0, `MSE_VERSION});
    flags[5] = cause[`MSE_POR_BIT];
  endtask
  task automatic read_at(input logic [15:0] a, input logic sec);
    logic [8:0] v;
    send_echo(`MSE_CMD_READ);
    send_echo(a[15:8]);
    send_echo(a[7:0]);
    get_rx(v);
    cmp(v, {1'b0, mem_exp(a, sec)});
    vec_filler = vec_filler & (v[7:0] === `MSE_FILLER);
  endtask
  // Reads the whole vector area and checks the seven recorded status flags.
  task automatic sweep(input logic por, input logic sec);
    vec_filler = 1'b1;
    for (int i = 0; i < 10; i++)
      read_at(16'hFFF6 + 16'(i), sec);
    flags[6] = !vec_filler;
    cmp({2'b00, flags}, {2'b00, !sec, por, 5'h1F});
  endtask
  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    por_cause = 1'b0;
    bad_count = 0;
    n_compared = 0;
    seed = 32'hd2b4;
    key = {$random(seed), $random(seed)};
    entry(1'b1, key, 1'b0);
    sweep(1'b1, 1'b0);
    read_at(16'hC000, 1'b0);
    read_at(16'h7FFF, 1'b0);
    repeat (4) read_at(16'($random(seed)), 1'b0);
    entry(1'b0, key ^ 64'h0000_0100_0000_0000, 1'b1);
    sweep(1'b0, 1'b1);
    read_at(16'h8000, 1'b1);
    read_at(16'hBFFF, 1'b1);
    repeat (4) read_at(16'($random(seed)), 1'b1);
    summarize;
  end
endmodule
`default_nettype wire
